// file: rtl/lnpt_pkg.sv
// Offsets, field layout, reset values and load map of the config and pause timer bank.
// Assumes a 32-bit APB slave with byte addresses and 16-bit nonvolatile words.
package lnpt_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [15:0] OFF_CFG_FOUR  = 16'h0024;
    localparam logic [15:0] OFF_CFG_TWO   = 16'h0030;
    localparam logic [15:0] OFF_PCI_LOC   = 16'h0038;
    localparam logic [15:0] OFF_CFG_THREE = 16'h003c;
    localparam logic [15:0] OFF_PAUSE_VAL = 16'h0170;
    localparam logic [15:0] OFF_REFRESH   = 16'h5f40;

    // Reset values
    localparam logic [31:0] RST_NVM_CFG  = 32'h0000_0000;
    localparam logic [15:0] RST_PAUSE    = 16'h0000;
    localparam logic [15:0] RST_REFRESH  = 16'h0000;
    localparam logic [7:0]  RST_BUS_NUM  = 8'h00;

    // Nonvolatile word numbers: index 0 two, 1 three, 2 four
    localparam int unsigned NVM_REGS = 3;
    localparam logic [7:0] NVM_LO_WORD [NVM_REGS] = '{8'h24, 8'h26, 8'h2a};
    localparam logic [7:0] NVM_HI_WORD [NVM_REGS] = '{8'h25, 8'h27, 8'h2b};
    localparam int unsigned NVM_IDX_FOUR = 2;

    // Field positions
    localparam int unsigned PLL_SHUT_BIT = 29;
    localparam int unsigned PLL_NVM_BIT  = 13;
    localparam int unsigned FUNC_LSB     = 8;
    localparam int unsigned DEV_LSB      = 11;
    localparam int unsigned BUS_LSB      = 16;
    localparam int unsigned HALF_W       = 16;
    localparam logic [2:0]  FUNC_NUM     = 3'h0;
    localparam logic [4:0]  DEV_NUM      = 5'h19;

    // Slot time in byte times
    localparam int unsigned SLOT_BYTES = 64;

    typedef enum logic [2:0] {
        LNPT_SEL_NONE  = 3'b000,
        LNPT_SEL_TWO   = 3'b001,
        LNPT_SEL_THREE = 3'b010,
        LNPT_SEL_FOUR  = 3'b011,
        LNPT_SEL_LOC   = 3'b100,
        LNPT_SEL_PTIME = 3'b101,
        LNPT_SEL_RTHR  = 3'b110
    } lnpt_sel_t;

    typedef enum logic [1:0] {
        LNPT_RF_IDLE  = 2'b00,
        LNPT_RF_COUNT = 2'b01,
        LNPT_RF_WAIT  = 2'b10
    } lnpt_rf_t;

endpackage : lnpt_pkg

// file: rtl/lnpt_slot_tick.sv
// Slot time tick generator for the flow control timers.
// Assumes byte_tick pulses once per byte time on the link.
`timescale 1ns/1ps
module lnpt_slot_tick #(
    parameter int unsigned SLOT_BYTES = lnpt_pkg::SLOT_BYTES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Byte time in, slot time out
    input  wire logic byte_tick,
    output logic      slot_tick
);

    localparam int unsigned CW = $clog2(SLOT_BYTES);
    localparam logic [CW-1:0] LAST = CW'(SLOT_BYTES - 1);

    logic [CW-1:0] byte_cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_cnt_r <= '0;
        end else if (byte_tick) begin
            byte_cnt_r <= (byte_cnt_r == LAST) ? '0 : byte_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_tick <= 1'b0;
        end else begin
            slot_tick <= byte_tick && (byte_cnt_r == LAST);
        end
    end

endmodule : lnpt_slot_tick

// file: rtl/lnpt_regs.sv
// Config bank loaded from nonvolatile words, PCI location and pause timers.
// Assumes presetn is the LAN power good reset; other resets arrive as sync pulses.
// Assumes a frame builder downstream forms pause frames and reports each XOFF.
`timescale 1ns/1ps
module lnpt_regs #(
    parameter int unsigned SLOT_BYTES = lnpt_pkg::SLOT_BYTES
) (
    // Clock and power good reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Nonvolatile word loader
    input  wire logic        nvm_load_valid,
    input  wire logic [7:0]  nvm_load_word,
    input  wire logic [15:0] nvm_load_data,
    // PCI side events
    input  wire logic        pci_reset_pulse,
    input  wire logic        d3_to_d0_pulse,
    input  wire logic        cfg_type0_wr,
    input  wire logic [7:0]  cfg_bus_num,
    // Low power link state
    input  wire logic        link_up_gig,
    input  wire logic        pll_shut_req,
    output logic             pll_shut_ok,
    // Flow control
    input  wire logic        byte_tick,
    input  wire logic        pause_cond,
    input  wire logic        xoff_sent,
    output logic             refresh_xoff_req,
    output logic [15:0]      pause_time_field
);

    // Address decode shared by read and write paths
    function automatic lnpt_pkg::lnpt_sel_t reg_sel(input logic [15:0] addr);
        lnpt_pkg::lnpt_sel_t s;
        s = lnpt_pkg::LNPT_SEL_NONE;
        if (addr == lnpt_pkg::OFF_CFG_TWO) begin
            s = lnpt_pkg::LNPT_SEL_TWO;
        end else if (addr == lnpt_pkg::OFF_CFG_THREE) begin
            s = lnpt_pkg::LNPT_SEL_THREE;
        end else if (addr == lnpt_pkg::OFF_CFG_FOUR) begin
            s = lnpt_pkg::LNPT_SEL_FOUR;
        end else if (addr == lnpt_pkg::OFF_PCI_LOC) begin
            s = lnpt_pkg::LNPT_SEL_LOC;
        end else if (addr == lnpt_pkg::OFF_PAUSE_VAL) begin
            s = lnpt_pkg::LNPT_SEL_PTIME;
        end else if (addr == lnpt_pkg::OFF_REFRESH) begin
            s = lnpt_pkg::LNPT_SEL_RTHR;
        end
        return s;
    endfunction : reg_sel

    // Byte lane merge for a write
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge_strb

    lnpt_pkg::lnpt_sel_t sel;
    logic                wr_fire;
    logic [31:0]         nvm_cfg_r [lnpt_pkg::NVM_REGS];
    logic [7:0]          bus_num_r;
    logic [15:0]         ptime_r;
    logic [15:0]         rthr_r;
    logic [31:0]         rd_nxt;
    logic [31:0]         loc_word;
    logic                slot_tick;
    logic                gig_gate;

    assign sel     = reg_sel(paddr);
    // Write lands only at the completing access edge
    assign wr_fire = psel && penable && pready && pwrite;
    // Location register has no write path; such a write ends without error

    // APB answer: one wait-free access phase after every setup
    // No wait states: every register reads from flops or constants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // Unmapped address: error answer, no state changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && (sel == lnpt_pkg::LNPT_SEL_NONE);
        end
    end

    // Captured at setup, held through the access phase and after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // Fixed function and device numbers beside the captured bus number
    always_comb begin
        loc_word = 32'h0000_0000;
        loc_word[lnpt_pkg::FUNC_LSB +: 3] = lnpt_pkg::FUNC_NUM;
        loc_word[lnpt_pkg::DEV_LSB +: 5]  = lnpt_pkg::DEV_NUM;
        loc_word[lnpt_pkg::BUS_LSB +: 8]  = bus_num_r;
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (sel)
            lnpt_pkg::LNPT_SEL_TWO: begin
                rd_nxt = nvm_cfg_r[0];
            end
            lnpt_pkg::LNPT_SEL_THREE: begin
                rd_nxt = nvm_cfg_r[1];
            end
            lnpt_pkg::LNPT_SEL_FOUR: begin
                rd_nxt = nvm_cfg_r[2];
            end
            lnpt_pkg::LNPT_SEL_LOC: begin
                rd_nxt = loc_word;
            end
            lnpt_pkg::LNPT_SEL_PTIME: begin
                rd_nxt = {16'h0000, ptime_r};
            end
            lnpt_pkg::LNPT_SEL_RTHR: begin
                rd_nxt = {16'h0000, rthr_r};
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Nonvolatile-loaded config registers; a load beats a software write
    // in the same cycle so the loader image is never half overwritten.
    // Software writes merge by byte lane; reserved bits keep what is written.
    for (genvar i = 0; i < lnpt_pkg::NVM_REGS; i++) begin : g_nvm_cfg
        lnpt_pkg::lnpt_sel_t my_sel;
        logic                ld_lo;
        logic                ld_hi;

        assign my_sel = (i == 0) ? lnpt_pkg::LNPT_SEL_TWO
                      : (i == 1) ? lnpt_pkg::LNPT_SEL_THREE
                      : lnpt_pkg::LNPT_SEL_FOUR;
        assign ld_lo  = nvm_load_valid && (nvm_load_word == lnpt_pkg::NVM_LO_WORD[i]);
        assign ld_hi  = nvm_load_valid && (nvm_load_word == lnpt_pkg::NVM_HI_WORD[i]);

        // Only the power good reset reaches these flops
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                nvm_cfg_r[i] <= lnpt_pkg::RST_NVM_CFG;
            end else if (ld_lo) begin
                nvm_cfg_r[i][0 +: lnpt_pkg::HALF_W] <= nvm_load_data;
            end else if (ld_hi) begin
                // Bit 13 of the high word lands on bit 29
                nvm_cfg_r[i][lnpt_pkg::HALF_W +: lnpt_pkg::HALF_W] <= nvm_load_data;
            end else if (wr_fire && (sel == my_sel)) begin
                nvm_cfg_r[i] <= merge_strb(nvm_cfg_r[i], pwdata, pstrb);
            end
        end
    end

    // Bus number: clears win over a capture in the same cycle
    // Otherwise a capture racing a PCI reset would outlive that reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_num_r <= lnpt_pkg::RST_BUS_NUM;
        end else if (pci_reset_pulse || d3_to_d0_pulse) begin
            bus_num_r <= lnpt_pkg::RST_BUS_NUM;
        end else if (cfg_type0_wr) begin
            bus_num_r <= cfg_bus_num;
        end
    end

    // Pause time value, low half only is storage
    // Upper half is not stored, so it always reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptime_r <= lnpt_pkg::RST_PAUSE;
        end else if (wr_fire && (sel == lnpt_pkg::LNPT_SEL_PTIME)) begin
            ptime_r <= 16'(merge_strb({16'h0000, ptime_r}, pwdata, pstrb));
        end
    end

    // Refresh threshold, low half only is storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rthr_r <= lnpt_pkg::RST_REFRESH;
        end else if (wr_fire && (sel == lnpt_pkg::LNPT_SEL_RTHR)) begin
            rthr_r <= 16'(merge_strb({16'h0000, rthr_r}, pwdata, pstrb));
        end
    end

    // Frame builder samples this for hardware and software pause frames;
    // a resume frame needs software to have written zero first.
    // Seen one cycle after the write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_time_field <= lnpt_pkg::RST_PAUSE;
        end else begin
            pause_time_field <= ptime_r;
        end
    end

    // PLL shutdown approval in the low power link state
    // Gate only at gigabit speed while the loaded enable bit is clear
    assign gig_gate = link_up_gig
        && !nvm_cfg_r[lnpt_pkg::NVM_IDX_FOUR][lnpt_pkg::PLL_SHUT_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_shut_ok <= 1'b0;
        end else begin
            pll_shut_ok <= pll_shut_req && !gig_gate;
        end
    end

    // One slot time paces every flow control timer here

    lnpt_slot_tick #(
        .SLOT_BYTES (SLOT_BYTES)
    ) u_slot (
        .pclk      (pclk),
        .presetn   (presetn),
        .byte_tick (byte_tick),
        .slot_tick (slot_tick)
    );

    // Refresh shadow counter and its small control machine
    lnpt_pkg::lnpt_rf_t rf_state_r;
    lnpt_pkg::lnpt_rf_t rf_state_nxt;
    logic [15:0]        shadow_r;
    logic               refresh_on;
    logic               at_thresh;

    // Zero threshold parks the machine in idle
    assign refresh_on = (rthr_r != 16'h0000);
    assign at_thresh  = (shadow_r == rthr_r);

    always_comb begin
        rf_state_nxt = rf_state_r;
        case (rf_state_r)
            lnpt_pkg::LNPT_RF_IDLE: begin
                // Arms on the next XOFF; a threshold written mid-pause waits
                if (xoff_sent && refresh_on) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_COUNT;
                end
            end
            lnpt_pkg::LNPT_RF_COUNT: begin
                if (!refresh_on || !pause_cond) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_IDLE;
                end else if (xoff_sent) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_COUNT;
                end else if (at_thresh) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_WAIT;
                end
            end
            lnpt_pkg::LNPT_RF_WAIT: begin
                // Hold one request until the XOFF actually leaves
                if (!refresh_on || !pause_cond) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_IDLE;
                end else if (xoff_sent) begin
                    rf_state_nxt = lnpt_pkg::LNPT_RF_COUNT;
                end
            end
            default: begin
                rf_state_nxt = lnpt_pkg::LNPT_RF_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_state_r <= lnpt_pkg::LNPT_RF_IDLE;
        end else begin
            rf_state_r <= rf_state_nxt;
        end
    end

    // Counts slots, not bytes; restarts on every XOFF
    // Holds at the threshold so one XOFF yields at most one request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_r <= 16'h0000;
        end else if (xoff_sent || rf_state_r == lnpt_pkg::LNPT_RF_IDLE) begin
            shadow_r <= 16'h0000;
        end else if (rf_state_r == lnpt_pkg::LNPT_RF_COUNT && slot_tick && !at_thresh) begin
            shadow_r <= shadow_r + 16'h0001;
        end
    end

    // One-cycle request, one cycle after the counter reaches the threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_xoff_req <= 1'b0;
        end else begin
            refresh_xoff_req <= (rf_state_r == lnpt_pkg::LNPT_RF_COUNT)
                && (rf_state_nxt == lnpt_pkg::LNPT_RF_WAIT);
        end
    end

endmodule : lnpt_regs

// file: testbench/lnpt_regs_monitor.sv
// Port checker for the config and pause timer bank.
// Assumes it is bound into lnpt_regs and sees only its ports.
`timescale 1ns/1ps
module lnpt_regs_monitor #(
    parameter int unsigned SLOT_BYTES = 64
) (
    // APB
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  pstrb,
    // Loader
    input wire logic        nvm_load_valid,
    input wire logic [7:0]  nvm_load_word,
    input wire logic [15:0] nvm_load_data, pause_time_field,
    // Link side
    input wire logic        link_up_gig, pll_shut_req, pll_shut_ok,
    input wire logic        byte_tick, pause_cond, xoff_sent, refresh_xoff_req
);
    logic [7:0] ticks_r;
    // Byte times since the last XOFF; slot phase is free running, so only nonzero is sure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ticks_r <= 8'h00;
        else if (xoff_sent) ticks_r <= 8'h00;
        else if (byte_tick && ticks_r != 8'hff) ticks_r <= ticks_r + 8'h01;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    loc_ids_a: assert property (psel && !penable && !pwrite && paddr == 16'h0038
        |=> prdata[15:0] == 16'hc800 && prdata[31:24] == 8'h00)
        else $error("fixed location fields wrong");
    upper_zero_a: assert property (psel && !penable && !pwrite
        && (paddr == 16'h0170 || paddr == 16'h5f40) |=> prdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    ptime_field_a: assert property (psel && penable && pready && pwrite
        && paddr == 16'h0170 && pstrb == 4'hf |=> ##1 pause_time_field == $past(pwdata[15:0], 2))
        else $error("pause time field not updated");
    pll_req_a: assert property (pll_shut_ok |-> $past(pll_shut_req))
        else $error("shutdown approved without request");
    pll_nogig_a: assert property (!link_up_gig && pll_shut_req |=> pll_shut_ok)
        else $error("shutdown gated without gigabit link");
    nvm_pll_a: assert property (nvm_load_valid && nvm_load_word == 8'h2b
        && nvm_load_data[13] ##1 (link_up_gig && pll_shut_req) [*2] |-> pll_shut_ok)
        else $error("loaded gate bit ignored");
    refresh_pulse_a: assert property (refresh_xoff_req |=> !refresh_xoff_req)
        else $error("refresh request longer than one cycle");
    refresh_cond_a: assert property (refresh_xoff_req |-> $past(pause_cond))
        else $error("refresh without pause condition");
    refresh_tick_a: assert property (refresh_xoff_req |-> ticks_r != 8'h00)
        else $error("refresh without any byte time since XOFF");
    cover property (refresh_xoff_req);
    cover property (pslverr);
    cover property (pll_shut_ok && link_up_gig);
endmodule : lnpt_regs_monitor

bind lnpt_regs lnpt_regs_monitor #(.SLOT_BYTES(SLOT_BYTES)) mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .nvm_load_valid(nvm_load_valid), .nvm_load_word(nvm_load_word),
    .nvm_load_data(nvm_load_data), .pause_time_field(pause_time_field),
    .link_up_gig(link_up_gig), .pll_shut_req(pll_shut_req), .pll_shut_ok(pll_shut_ok),
    .byte_tick(byte_tick), .pause_cond(pause_cond), .xoff_sent(xoff_sent),
    .refresh_xoff_req(refresh_xoff_req));

// file: testbench/lnpt_link_model.sv
// Link side model: byte times, XOFF frames and the pause time each carries.
// Assumes the bench paces byte times and may order a frame at will.
`timescale 1ns/1ps
module lnpt_link_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench controls
    input  wire logic        tick_en,
    input  wire logic        send_now,
    input  wire logic        slow,
    // Block side
    input  wire logic        refresh_xoff_req,
    input  wire logic [15:0] pause_time_field,
    output logic             byte_tick,
    output logic             xoff_sent,
    output logic [15:0]      frame_time
);
    logic [2:0] pend_r;
    assign byte_tick = tick_en;
    // Refresh answered after two or six cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r     <= 3'h0;
            xoff_sent  <= 1'b0;
            frame_time <= 16'h0000;
        end else begin
            xoff_sent <= 1'b0;
            if (refresh_xoff_req) pend_r <= slow ? 3'h5 : 3'h1;
            else if (pend_r != 3'h0) pend_r <= pend_r - 3'h1;
            if (send_now || pend_r == 3'h1) begin
                xoff_sent  <= 1'b1;
                frame_time <= pause_time_field;
            end
        end
    end
endmodule : lnpt_link_model

// file: testbench/lnpt_regs_tb.sv
// Self-checking bench for the config and pause timer bank.
// Assumes lnpt_regs at its default slot length and the link model beside it.
`timescale 1ns/1ps
module lnpt_regs_tb;
    logic        pclk, pready, pslverr, pll_shut_ok, xoff_sent, refresh_xoff_req, byte_tick;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic        nvm_load_valid = 1'b0, pci_reset_pulse = 1'b0, d3_to_d0_pulse = 1'b0;
    logic        cfg_type0_wr = 1'b0, link_up_gig = 1'b0, pll_shut_req = 1'b0;
    logic        pause_cond = 1'b0, tick_en = 1'b0, send_now = 1'b0;
    logic [15:0] paddr = 16'h0000, nvm_load_data = 16'h0000, pause_time_field, frame_time;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic [7:0]  nvm_load_word = 8'h00, cfg_bus_num = 8'h00;
    int          fail_count, total_checks, req_seen;

    localparam int SLOT = lnpt_pkg::SLOT_BYTES;

    lnpt_regs #(.SLOT_BYTES(SLOT)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .nvm_load_valid(nvm_load_valid), .nvm_load_word(nvm_load_word),
        .nvm_load_data(nvm_load_data), .pci_reset_pulse(pci_reset_pulse),
        .d3_to_d0_pulse(d3_to_d0_pulse), .cfg_type0_wr(cfg_type0_wr),
        .cfg_bus_num(cfg_bus_num), .link_up_gig(link_up_gig), .pll_shut_req(pll_shut_req),
        .pll_shut_ok(pll_shut_ok), .byte_tick(byte_tick), .pause_cond(pause_cond),
        .xoff_sent(xoff_sent), .refresh_xoff_req(refresh_xoff_req),
        .pause_time_field(pause_time_field));
    lnpt_link_model link_u (
        .pclk(pclk), .presetn(presetn), .tick_en(tick_en), .send_now(send_now), .slow(slow),
        .refresh_xoff_req(refresh_xoff_req), .pause_time_field(pause_time_field),
        .byte_tick(byte_tick), .xoff_sent(xoff_sent), .frame_time(frame_time));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (refresh_xoff_req === 1'b1) req_seen++;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        chk("pslverr", {31'h0, a == 16'h0044}, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(what, exp, r);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic send_xoff();
        send_now <= 1'b1;
        @(posedge pclk);
        send_now <= 1'b0;
    endtask : send_xoff
    // Byte counts stay whole slots so the free slot phase is known
    task automatic run_bytes(input int n);
        tick_en <= 1'b1;
        repeat (n) @(posedge pclk);
        tick_en <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : run_bytes

    task automatic t_reset_vals();
        rd(16'h0030, 32'h0000_0000, "cfg_two");
        rd(16'h003c, 32'h0000_0000, "cfg_three");
        rd(16'h0024, 32'h0000_0000, "cfg_four");
        rd(16'h0038, 32'h0000_c800, "location");
        rd(16'h0044, 32'h0000_0000, "unmapped");
    endtask : t_reset_vals
    task automatic t_nvm();
        logic [7:0] words [6] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h2a, 8'h2b};
        link_up_gig  <= 1'b1;
        pll_shut_req <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            nvm_load_valid <= 1'b1;
            nvm_load_word  <= words[i];
            nvm_load_data  <= {words[i], 8'h5a};
            @(posedge pclk);
        end
        nvm_load_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("pll_open", 32'h1, {31'h0, pll_shut_ok});
        rd(16'h0030, 32'h255a_245a, "cfg_two_load");
        rd(16'h003c, 32'h275a_265a, "cfg_three_load");
        rd(16'h0024, 32'h2b5a_2a5a, "cfg_four_load");
        wr(16'h0024, 32'h0b5a_2a5a);
        repeat (2) @(posedge pclk);
        chk("pll_gated", 32'h0, {31'h0, pll_shut_ok});
        link_up_gig <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("pll_no_gig", 32'h1, {31'h0, pll_shut_ok});
    endtask : t_nvm
    task automatic t_bus_num();
        for (int k = 0; k < 2; k++) begin
            cfg_bus_num  <= 8'h5a + 8'(k);
            cfg_type0_wr <= 1'b1;
            @(posedge pclk);
            cfg_type0_wr <= 1'b0;
            wr(16'h0038, 32'hffff_ffff);
            rd(16'h0038, {8'h00, 8'h5a + 8'(k), 16'hc800}, "bus_captured");
            pci_reset_pulse <= (k == 0);
            d3_to_d0_pulse  <= (k == 1);
            @(posedge pclk);
            pci_reset_pulse <= 1'b0;
            d3_to_d0_pulse  <= 1'b0;
            rd(16'h0038, 32'h0000_c800, "bus_cleared");
            rd(16'h0030, 32'h255a_245a, "cfg_two_kept");
        end
    endtask : t_bus_num
    task automatic t_refresh();
        wr(16'h0170, 32'hffff_1234);
        rd(16'h0170, 32'h0000_1234, "pause_time");
        chk("pause_field", 32'h0000_1234, {16'h0, pause_time_field});
        wr(16'h5f40, 32'hffff_0002);
        rd(16'h5f40, 32'h0000_0002, "refresh_thr");
        pause_cond <= 1'b1;
        send_xoff();
        run_bytes(SLOT);
        chk("req_one_slot", 32'h0, req_seen);
        run_bytes(SLOT);
        chk("req_two_slots", 32'h1, req_seen);
        chk("frame_time", 32'h0000_1234, {16'h0, frame_time});
        slow <= 1'b1;
        run_bytes(2 * SLOT);
        chk("req_restart", 32'h2, req_seen);
        wr(16'h5f40, 32'h0000_0000);
        send_xoff();
        run_bytes(3 * SLOT);
        chk("req_thr_zero", 32'h2, req_seen);
        wr(16'h5f40, 32'h0000_0001);
        pause_cond <= 1'b0;
        send_xoff();
        run_bytes(2 * SLOT);
        chk("req_no_pause", 32'h2, req_seen);
        wr(16'h0170, 32'h0000_0000);
        send_xoff();
        repeat (3) @(posedge pclk);
        chk("xon_time", 32'h0, {16'h0, frame_time});
    endtask : t_refresh
    task automatic t_power_good();
        cfg_bus_num  <= 8'h77;
        cfg_type0_wr <= 1'b1;
        @(posedge pclk);
        cfg_type0_wr <= 1'b0;
        presetn      <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(16'h0024, 32'h0000_0000, "cfg_four_pg");
        rd(16'h0038, 32'h0000_c800, "bus_pg");
    endtask : t_power_good

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_nvm();
        t_bus_num();
        t_refresh();
        t_power_good();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        conclude();
    end
endmodule : lnpt_regs_tb
